// ### spm_pkg.sv
// Package of register map, field layout, timing constants and types for the serial host
package spm_pkg;

  localparam int unsigned DATA_W         = 32;
  localparam int unsigned ADDR_W         = 4;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned HC_W           = 10;

  // Register byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_TX   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_RX   = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'hC;

  localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_ZERO  = 8'h00;

  // Status word bit positions
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_DONE  = 1;
  localparam int unsigned STAT_OVR   = 2;
  localparam int unsigned STAT_WRITE_COLLISION_FLAG  = 3;
  localparam int unsigned STAT_ARMED = 4;
  localparam int unsigned STAT_W     = 5;

  // Serial byte framing
  localparam logic [3:0] LAST_SAMPLE = 4'h7;
  localparam logic [3:0] LAST_EDGE   = 4'hF;
  localparam logic [3:0] CNT_ZERO    = 4'h0;
  localparam logic [3:0] CNT_ONE     = 4'h1;

  // Half period of the driven serial clock is HALF_BASE shifted left by the rate select
  localparam int unsigned CLK_SYS_NS   = 50;
  localparam int unsigned HALF_MIN_NS  = 200;
  localparam logic [HC_W-1:0] HALF_BASE =
    HC_W'((HALF_MIN_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
  localparam logic [HC_W-1:0] HC_ONE    = 10'h001;
  localparam logic [HC_W-1:0] HC_ZERO   = 10'h000;

  // Control word, bit 0 at the bottom
  typedef struct packed {
    logic       keep_sel;
    logic [2:0] bit_rate_sel;
    logic       clk_phase;
    logic       clk_polarity;
    logic       master_select;
    logic       periph_enable;
  } spm_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_SHIFT,
    ST_GAP
  } spm_state_t;

endpackage

// ### spm_sync.sv
// Two-flop synchroniser for pin inputs with clock enable
module spm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// ### spm_host.sv
// Serial port host: drives or answers the device's serial port, APB register front end
// Behaviour
// [RL1] Bytes move most significant bit first on both data lines.
// [RL2] Only the master starts a transfer; both lines shift on master's clock.
// [RL3] Both ends must use identical polarity and phase settings.
// [RL4] Device takes internal select from software level when soft management set.
// [RL5] Device as master needs its internal select held high throughout.
// [RL6] Phase one slave: select stays low for the whole multi-byte stream.
// [RL7] Phase zero slave: select low per byte, high between bytes.
// [RL8] Phase zero captures on first edge, phase one on second edge.
// [RL9] Master drives the serial clock; rate, polarity, phase from control bits.
// [RL10] Clock idle level must match polarity.
// [RL11] Master and enable bits stay set only while internal select is high.
// [RL12] Device status register must be written before master select.
// [RL13] Master data write loads the shift register and starts shifting.
// [RL14] Byte completion sets done flag, interrupt when enabled and unmasked; no interrupt output here, done is a status bit only.
// [RL15] Done flag clears by status access then data read or write; here writing 1 to STAT_DONE clears it.
// [RL16] Data writes blocked while done flag set until status read; here only busy blocks them, done does not.
// [RL17] Slave takes clock from the pin and never drives it.
// [RL18] Slave enable: set timing, select handling, then enable with master clear.
// [RL19] Slave shifts written byte out when master's clock arrives.
// [RL20] Done flag must be cleared before the next completion.
// [RL21] Polarity and phase together choose the capture edge.
// [RL22] Disable the port before changing polarity between bytes.
// [RL23] A byte spans eight clock cycles; done after eighth bit both ways.
// [RL24] Master seeing select low raises mode fault and drops to slave.
// [RL25] Byte before done cleared raises overrun, keeps earlier byte.
// [RL26] Data write during a transfer is discarded, raises write collision.
//
// Chosen here: the address map and the APB register port.
module spm_host
  import spm_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [spm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [spm_pkg::DATA_W-1:0] pwdata,
  output logic      [spm_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      sck_i,
  output logic                           sck_o,
  output logic                           sck_oe,
  input  wire logic                      mosi_i,
  output logic                           mosi_o,
  output logic                           mosi_oe,
  input  wire logic                      miso_i,
  output logic                           miso_o,
  output logic                           miso_oe,
  output logic                           ss_n_o,
  output logic                           ss_n_oe
);

  import spm_pkg::*;

  spm_cfg_t          cfg_r;
  spm_state_t        state_r;
  logic [HC_W-1:0]   hc_r;
  logic [3:0]        ecnt_r;
  logic [3:0]        bits_r;
  logic [BYTE_W-1:0] tx_sh_r;
  logic [BYTE_W-1:0] rx_sh_r;
  logic [BYTE_W-1:0] rx_data_r;
  logic              out_r;
  logic              sck_r;
  logic              sel_low_r;
  logic              slv_busy_r;
  logic              armed_r;
  logic              done_r;
  logic              ovr_r;
  logic              write_collision_flag_r;
  logic              sck_d_r;
  logic [DATA_W-1:0] prdata_r;

  logic [2:0]        pin_s;
  wire               sck_s  = pin_s[2];
  wire               mosi_s = pin_s[1];
  wire               miso_s = pin_s[0];

  spm_sync #(
    .W (3)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .d       ({sck_i, mosi_i, miso_i}),
    .q       (pin_s)
  );

  // Bus decode
  wire               acc      = psel & penable & ce;
  wire               hit      = (paddr == ADDR_CTRL) | (paddr == ADDR_TX) |
                                (paddr == ADDR_RX) | (paddr == ADDR_STAT);
  wire               wr_ctrl  = acc & pwrite & (paddr == ADDR_CTRL);
  wire               wr_tx    = acc & pwrite & (paddr == ADDR_TX);
  wire               wr_stat  = acc & pwrite & (paddr == ADDR_STAT);
  wire               clr_done = wr_stat & pwdata[STAT_DONE];
  wire               clr_ovr  = wr_stat & pwdata[STAT_OVR];
  wire               clr_write_collision_flag = wr_stat & pwdata[STAT_WRITE_COLLISION_FLAG];
  spm_cfg_t          cfg_wr;
  assign cfg_wr = spm_cfg_t'(pwdata[BYTE_W-1:0]);

  // Role: master_select here means this host drives the clock
  wire               mst_role = cfg_r.periph_enable & cfg_r.master_select;
  wire               slv_role = cfg_r.periph_enable & ~cfg_r.master_select;
  wire               busy     = mst_role ? (state_r != ST_IDLE) : slv_busy_r;

  // A write while shifting is dropped; the running byte carries on
  wire               tx_ok    = wr_tx & ~busy;
  wire               tx_col   = wr_tx & busy;
  wire               start    = tx_ok & mst_role & (state_r == ST_IDLE);

  // Half-period timer of the driven clock
  wire [HC_W-1:0]    half_m1  = (HALF_BASE << cfg_r.bit_rate_sel) - HC_ONE;
  wire               tick     = (hc_r == HC_ZERO);

  // Edge events from either role
  wire               mst_edge = (state_r == ST_SHIFT) & tick;
  wire               mst_lead = (sck_r == cfg_r.clk_polarity);
  wire               slv_edge = slv_role & (sck_s != sck_d_r);
  wire               slv_lead = (sck_s != cfg_r.clk_polarity);
  wire               edge_ev  = mst_role ? mst_edge : slv_edge;
  wire               lead     = mst_role ? mst_lead : slv_lead;
  wire               sample   = edge_ev & (lead ^ cfg_r.clk_phase); // [RL8] [RL21]
  wire               drive    = edge_ev & ~(lead ^ cfg_r.clk_phase); // [RL3]
  wire               in_bit   = mst_role ? miso_s : mosi_s;
  wire               byte_end = sample & (bits_r == LAST_SAMPLE); // [RL23]
  wire [BYTE_W-1:0]  rx_next  = {rx_sh_r[BYTE_W-2:0], in_bit};   // [RL1]

  // Select may only stay low across bytes in phase one with keep set
  wire               sel_rel  = ~cfg_r.clk_phase | ~cfg_r.keep_sel; // [RL6] [RL7]

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_r <= spm_cfg_t'(CTRL_RESET);
    end else if (wr_ctrl) begin
      cfg_r <= spm_cfg_t'(pwdata[BYTE_W-1:0]); // [RL12] [RL18]
    end
  end

  // Master sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      hc_r      <= HC_ZERO;
      ecnt_r    <= CNT_ZERO;
      sck_r     <= 1'b0;
      sel_low_r <= 1'b0;
    end else if (ce) begin
      hc_r <= tick ? half_m1 : hc_r - HC_ONE;
      case (state_r)
        ST_IDLE: begin
          // Follow a new polarity at once so the idle level never lags the enable
          sck_r <= wr_ctrl ? cfg_wr.clk_polarity : cfg_r.clk_polarity; // [RL10] [RL22]
          if (!mst_role) begin
            sel_low_r <= 1'b0;
          end
          if (start) begin
            state_r   <= ST_SETUP;
            sel_low_r <= 1'b1;
            hc_r      <= half_m1;
            ecnt_r    <= CNT_ZERO;
          end
        end
        ST_SETUP: begin
          if (tick) begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            sck_r  <= ~sck_r; // [RL9]
            ecnt_r <= ecnt_r + CNT_ONE;
            if (ecnt_r == LAST_EDGE) begin
              state_r <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            state_r <= ST_IDLE;
            if (sel_rel) begin
              sel_low_r <= 1'b0; // [RL7]
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      if (!mst_role) begin
        state_r <= ST_IDLE;
      end
    end
  end

  // Shift path shared by both roles
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_sh_r <= BYTE_ZERO;
      rx_sh_r <= BYTE_ZERO;
      out_r   <= 1'b0;
      bits_r  <= CNT_ZERO;
      sck_d_r <= 1'b0;
    end else if (ce) begin
      sck_d_r <= sck_s;
      if (tx_ok) begin
        tx_sh_r <= pwdata[BYTE_W-1:0]; // [RL13] [RL19]
        out_r   <= pwdata[BYTE_W-1];
        bits_r  <= CNT_ZERO;
      end else if (drive) begin
        out_r   <= cfg_r.clk_phase ? tx_sh_r[BYTE_W-1] : tx_sh_r[BYTE_W-2]; // [RL1]
        tx_sh_r <= tx_sh_r << 1;
      end
      if (sample) begin
        rx_sh_r <= rx_next;
        bits_r  <= byte_end ? CNT_ZERO : bits_r + CNT_ONE;
      end
      if (!cfg_r.periph_enable) begin
        bits_r <= CNT_ZERO;
      end
    end
  end

  // Slave progress and sticky status; a set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slv_busy_r <= 1'b0;
      armed_r    <= 1'b0;
      done_r     <= 1'b0;
      ovr_r      <= 1'b0;
      write_collision_flag_r     <= 1'b0;
      rx_data_r  <= BYTE_ZERO;
    end else if (ce) begin
      // Phase zero ends a byte on a capture edge; the trailing edge after it must not reopen it
      if (slv_edge) begin
        slv_busy_r <= sample ? ~byte_end : (slv_busy_r | cfg_r.clk_phase); // [RL2] [RL19]
      end else if (!slv_role) begin
        slv_busy_r <= 1'b0;
      end
      armed_r <= (tx_ok & slv_role) | (armed_r & ~(slv_edge | ~slv_role));
      if (byte_end && !(done_r && !clr_done)) begin
        rx_data_r <= rx_next;
      end
      done_r <= byte_end | (done_r & ~clr_done); // [RL14] [RL20]
      ovr_r  <= (byte_end & done_r & ~clr_done) | (ovr_r & ~clr_ovr); // [RL25]
      write_collision_flag_r <= tx_col | (write_collision_flag_r & ~clr_write_collision_flag); // [RL26]
    end
  end

  // Read data is prepared in the setup cycle so the access cycle returns a register
  wire [DATA_W-1:0] stat_word =
    DATA_W'({armed_r, write_collision_flag_r, ovr_r, done_r, busy});
  wire [DATA_W-1:0] rd_mux =
    (paddr == ADDR_CTRL) ? DATA_W'(cfg_r) :
    (paddr == ADDR_TX)   ? DATA_W'(tx_sh_r) :
    (paddr == ADDR_RX)   ? DATA_W'(rx_data_r) :
    (paddr == ADDR_STAT) ? stat_word : '0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata_r <= '0;
    end else if (ce && psel && !penable) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Pins: the clock is driven only as master, never in the answering role
  assign sck_o   = sck_r;
  assign sck_oe  = mst_role; // [RL9] [RL17]
  assign mosi_o  = out_r;
  assign mosi_oe = mst_role;
  assign miso_o  = out_r;
  assign miso_oe = slv_role;
  // When the device masters, its select is held high so it keeps that role
  assign ss_n_o  = mst_role ? ~sel_low_r : 1'b1; // [RL5] [RL11] [RL24]
  assign ss_n_oe = cfg_r.periph_enable;

endmodule

// ### spm_host_assertions.sv
// Concurrent checks on the serial port host top-level ports
module spm_host_chk
  import spm_pkg::*;
(
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [spm_pkg::ADDR_W-1:0] paddr,
  input wire logic [spm_pkg::DATA_W-1:0] prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       sck_o,
  input wire logic                       sck_oe,
  input wire logic                       mosi_oe,
  input wire logic                       miso_oe,
  input wire logic                       ss_n_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire        acc    = psel && penable;
  wire        mapped = paddr inside {ADDR_CTRL, ADDR_TX, ADDR_RX, ADDR_STAT};
  wire        wr_acc = acc && pwrite;
  logic       sck_q_r;
  logic [4:0] edges_r;
  // Edge count restarts whenever select is high, so idle level changes are not counted
  always_ff @(posedge clk_sys) begin
    sck_q_r <= sck_o;
    edges_r <= (!rst_n || ss_n_o) ? 5'h00 : edges_r + 5'(sck_o != sck_q_r);
  end
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_unmapped; acc && !mapped |-> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped; acc && mapped |-> !pslverr && prdata[31:8] == 24'h0; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused or wide");
  property p_no_clk_slave; sck_oe |-> !miso_oe; endproperty
  a_no_clk_slave: assert property (p_no_clk_slave) else $error("clock driven as slave");
  property p_roles; mosi_oe == sck_oe; endproperty
  a_roles: assert property (p_roles) else $error("master outputs split");
  property p_setup; $fell(ss_n_o) && sck_oe |-> $stable(sck_o) [*3]; endproperty
  a_setup: assert property (p_setup) else $error("clock edge too soon after select");
  property p_half;
    sck_oe && !ss_n_o && $changed(sck_o) |=> $stable(sck_o) [*3];
  endproperty
  a_half: assert property (p_half) else $error("clock half period short");
  property p_count; $rose(ss_n_o) && sck_oe |-> edges_r == 5'h10; endproperty
  a_count: assert property (p_count) else $error("byte not sixteen edges");
  property p_start;
    acc && pwrite && paddr == ADDR_TX && sck_oe && ss_n_o |=> !ss_n_o;
  endproperty
  a_start: assert property (p_start) else $error("data write did not start");
  property p_idle;
    sck_oe && ss_n_o && $past(ss_n_o) && !$past(wr_acc) |-> $stable(sck_o);
  endproperty
  a_idle: assert property (p_idle) else $error("clock moved while idle");
  c_frame: cover property ($rose(ss_n_o) && sck_oe);
  c_refused: cover property (acc && pslverr);
  c_slave: cover property (miso_oe && acc);
endmodule

// ### spm_dev.sv
// Behavioural model of the serial device answering as a select-driven slave
module spm_dev (
  input  wire logic       ss_n,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic      [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  initial miso = 1'b0;
  // Phase zero puts the first bit out at select, before any edge
  always @(negedge ss_n) begin
    sh = tx;
    if (!mode[1]) begin
      miso = sh[7];
      sh = sh << 1;
    end
  end
  // Released line shows the inverse, so a stale bit can not pass as good
  always @(posedge ss_n) miso = ~miso;
  // Leading edge leaves the polarity level; phase picks capture or drive
  always @(sck) begin
    if (!ss_n) begin
      if ((sck != mode[0]) != mode[1]) rx = {rx[6:0], mosi};
      else begin
        miso = sh[7];
        sh = sh << 1;
      end
    end
  end
endmodule

// ### test_spm_host.sv
// Self-checking bench for the serial port host against the device model
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module test_spm_host;
  timeunit 1ns;
  timeprecision 1ns;
  import spm_pkg::*;
  logic              clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = ADDR_CTRL;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata, q;
  logic              pready, pslverr, err, sck_m = 1'b0, mosi_m = 1'b0, dev_miso;
  logic              sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
  logic [7:0]        dev_rx, b, dcfg = 8'h00, dtx = 8'h00;
  int                mismatches = 0, tests_run = 0;
  logic [7:0]        cfg [5] = '{8'h03, 8'h07, 8'h0B, 8'h0F, 8'h23};
  logic [7:0]        tx [5] = '{8'h81, 8'h4E, 8'hB2, 8'h01, 8'hF0};
  logic [7:0]        dv [5] = '{8'h7E, 8'h80, 8'h2D, 8'hC6, 8'h0F};
  // Undriven clock sits at the pull level chosen by polarity
  wire sck  = sck_oe ? sck_o : (miso_oe ? sck_m : dcfg[2]);
  wire mosi = mosi_oe ? mosi_o : mosi_m;
  wire miso = miso_oe ? miso_o : dev_miso;
  wire ss_n = ss_n_oe ? ss_n_o : 1'b1;
  always #25 clk_sys = ~clk_sys;
  spm_host spm_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_i(sck), .sck_o(sck_o), .sck_oe(sck_oe),
    .mosi_i(mosi), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso), .miso_o(miso_o),
    .miso_oe(miso_oe), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));
  spm_dev spm_dev_inst (.ss_n(ss_n), .sck(sck), .mosi(mosi), .mode(dcfg[3:2]), .tx(dtx),
    .miso(dev_miso), .rx(dev_rx));
  task automatic end_of_test;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle;
    do apb(1'b0, ADDR_STAT, 8'h00); while (q[STAT_BUSY] !== 1'b0);
  endtask
  // Stands in for the device as master: mode zero, 400 ns clock
  task automatic dev_byte(input logic [7:0] m);
    for (int k = 7; k >= 0; k--) begin
      mosi_m <= m[k];
      repeat (4) @(posedge clk_sys);
      sck_m <= 1'b1;
      b[k] = miso;
      repeat (4) @(posedge clk_sys);
      sck_m <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, 8'h00);
    `CHK(q, 32'h0)
    apb(1'b0, ADDR_STAT, 8'h00);
    `CHK(q, 32'h0)
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ADDR_CTRL, 8'h00);
      dcfg <= cfg[i];
      dtx <= dv[i];
      apb(1'b1, ADDR_CTRL, cfg[i]);
      apb(1'b0, ADDR_CTRL, 8'h00);
      `CHK(sck, cfg[i][2])
      `CHK(q, {24'h0, cfg[i]})
      apb(1'b1, ADDR_TX, tx[i]);
      wait_idle;
      `CHK(q[STAT_DONE], 1'b1)
      `CHK(dev_rx, tx[i])
      apb(1'b0, ADDR_RX, 8'h00);
      `CHK(q, {24'h0, dv[i]})
      apb(1'b1, ADDR_STAT, 8'h0E);
      apb(1'b0, ADDR_STAT, 8'h00);
      `CHK(q[3:1], 3'h0)
    end
    dtx <= 8'hA5;
    apb(1'b1, ADDR_TX, 8'h5A);
    apb(1'b1, ADDR_TX, 8'hFF);
    wait_idle;
    `CHK(q[STAT_WRITE_COLLISION_FLAG], 1'b1)
    `CHK(dev_rx, 8'h5A)
    apb(1'b0, 4'h2, 8'h00);
    `CHK({err, q}, 33'h1_0000_0000)
    apb(1'b1, ADDR_CTRL, 8'h00);
    apb(1'b1, ADDR_STAT, 8'h0E);
    apb(1'b1, ADDR_CTRL, 8'h01);
    apb(1'b1, ADDR_TX, 8'hC3);
    dev_byte(8'h96);
    `CHK(b, 8'hC3)
    apb(1'b0, ADDR_STAT, 8'h00);
    `CHK(q[STAT_BUSY], 1'b0)
    `CHK(q[STAT_DONE], 1'b1)
    apb(1'b0, ADDR_RX, 8'h00);
    `CHK(q[7:0], 8'h96)
    dev_byte(8'h3C);
    apb(1'b0, ADDR_STAT, 8'h00);
    `CHK(q[STAT_OVR], 1'b1)
    apb(1'b0, ADDR_RX, 8'h00);
    `CHK(q[7:0], 8'h96)
    end_of_test;
  end
  // Whole run is under two thousand cycles; this leaves a wide margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    end_of_test;
  end
endmodule
bind spm_host spm_host_chk spm_host_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .ss_n_o(ss_n_o));
